// [logic/autoneg_advertisement_reg.sv]
// auto-negotiation advertisement register with its apb slave, control and event logic
`timescale 1ns/100ps
// How it works
// - next-page bit 15 is writable, resets to zero, advertises next-page capability
// - remote-fault bit 13 follows local link fault and goes out in the code word
// - reserved bits 14 and 12..10 always read back as zero
// - override-protected bits take writes only while override control bit is one
// - 100BASE-T4 bit 9 is held at zero always
// - ability bits 8..5: one advertises, zero does not; TX full/half, T full/half
// - ability defaults depend on mode pin and auto-negotiation enable
// - negotiation disabled: idle, rate and duplex select fix the mode
// - negotiation enabled: ability bits default to all ones and are advertised
// - selector field defaults to 00001 and is override-protected
// - status ability bits report full capability regardless of advertisement
// - transmitted code word is built from this register while negotiation enabled
// - protected selector readable, protected reserved bits read zero; all writable only with override set
module autoneg_advertisement_reg (
	input wire logic pclk, // apb clock, 100 MHz
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address only
	input wire logic hardware_software_select_pin, // high selects hardware mode straps
	input wire logic strap_an_enable, // hardware mode negotiation enable level
	input wire logic strap_rate, // hardware mode rate, high for 100M
	input wire logic strap_duplex, // hardware mode duplex, high for full
	input wire logic local_fault, // local link problem detected, level
	output autoneg_pkg::link_code_word_t link_code_word, // word for fast link pulses
	output logic link_code_word_valid, // code word is being advertised
	output logic an_restart, // one-cycle restart request to negotiation
	output logic forced_idle, // negotiation skipped, transmit idles
	output logic forced_rate, // fixed rate while negotiation disabled
	output logic forced_duplex, // fixed duplex while negotiation disabled
	output logic [3:0] status_ability, // status register ability bits
	output logic irq // level interrupt, unmasked event pending
);
	logic next_page_r;
	logic remote_fault_r;
	logic ack_rsvd_r;
	logic [2:0] rsvd_r;
	logic [3:0] ability_r;
	logic [4:0] selector_r;
	autoneg_pkg::adv_ctrl_t ctrl_r;
	logic restart_r;
	logic [autoneg_pkg::EVT_W-1:0] evt_r;
	logic [autoneg_pkg::EVT_W-1:0] mask_r;
	logic [autoneg_pkg::EVT_W-1:0] evt_set;
	logic loaded_r;
	logic fault_d_r;
	logic [31:0] prdata_nxt;
	autoneg_pkg::link_code_word_t lcw_nxt;
	logic [3:0] ability_dflt;

	wire logic access = psel & penable;
	wire logic wr = access & pwrite;
	wire logic rd = access & ~pwrite;
	wire logic lo_en = pstrb[0];
	wire logic hi_en = pstrb[1];
	wire logic hit_adv = paddr == autoneg_pkg::ADV_OFFSET;
	wire logic hit_ctrl = paddr == autoneg_pkg::CTRL_OFFSET;
	wire logic hit_evt = paddr == autoneg_pkg::EVT_OFFSET;
	wire logic hit_mask = paddr == autoneg_pkg::MASK_OFFSET;
	wire logic hit_info = paddr == autoneg_pkg::INFO_OFFSET;
	wire logic mapped = hit_adv | hit_ctrl | hit_evt | hit_mask | hit_info;
	wire logic wr_adv = wr & hit_adv;
	wire logic wr_ctrl = wr & hit_ctrl & lo_en;
	wire logic any_lane = lo_en | hi_en;
	wire logic wr_adv_hi = wr_adv & hi_en;
	wire logic wr_adv_lo = wr_adv & lo_en;
	wire logic protect_open = ctrl_r.override_protected_write;
	wire logic wr_prot_hi = wr_adv & hi_en & protect_open;
	wire logic wr_prot_lo = wr_adv & lo_en & protect_open;
	// a blocked write notes an event and still writes the unprotected bits; the bus sees a normal answer
	wire logic blocked = wr_adv & ~protect_open;
	wire logic fault_rise = local_fault & ~fault_d_r;
	wire logic fault_fall = ~local_fault & fault_d_r;

	// apb: zero wait states; only unmapped addresses report an error
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// strap levels are caught on the first edge after reset release, never under reset
	always_comb begin
		// with negotiation strapped off only the strapped mode is offered, one-hot
		if (hardware_software_select_pin) begin
			ability_dflt = strap_an_enable ? autoneg_pkg::ABIL_AN_RST
				: 4'({strap_rate & strap_duplex, strap_rate & ~strap_duplex,
				~strap_rate & strap_duplex, ~strap_rate & ~strap_duplex});
		end else begin
			ability_dflt = autoneg_pkg::ABIL_AN_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_r <= 1'b0;
		end else begin
			loaded_r <= 1'b1;
		end
	end

	// control register: override, negotiation enable, rate, duplex
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '{override_protected_write: 1'b0, an_enable: 1'b1,
				rate_select: 1'b1, duplex_select: 1'b1};
		end else if (!loaded_r) begin
			if (hardware_software_select_pin) begin
				ctrl_r.an_enable <= strap_an_enable;
				ctrl_r.rate_select <= strap_rate;
				ctrl_r.duplex_select <= strap_duplex;
			end
		end else if (wr_ctrl) begin
			ctrl_r.override_protected_write <= pwdata[autoneg_pkg::CTRL_OVERRIDE_POS];
			ctrl_r.an_enable <= pwdata[autoneg_pkg::CTRL_AN_EN_POS];
			ctrl_r.rate_select <= pwdata[autoneg_pkg::CTRL_RATE_POS];
			ctrl_r.duplex_select <= pwdata[autoneg_pkg::CTRL_DUPLEX_POS];
		end
	end

	// restart is self-clearing; software issues it after changing the abilities
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restart_r <= 1'b0;
		end else begin
			restart_r <= wr_ctrl & pwdata[autoneg_pkg::CTRL_RESTART_POS];
		end
	end

	// writable advertisement bits; the first edge after reset belongs to the default load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			next_page_r <= autoneg_pkg::NEXT_PAGE_RST;
		end else if (loaded_r && wr_adv_hi) begin
			next_page_r <= pwdata[autoneg_pkg::NEXT_PAGE_POS];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ability_r <= autoneg_pkg::ABIL_AN_RST;
		end else if (!loaded_r) begin
			ability_r <= ability_dflt;
		end else begin
			if (wr_adv_hi) begin
				ability_r[3] <= pwdata[autoneg_pkg::ABIL_HI];
			end
			if (wr_adv_lo) begin
				ability_r[2:0] <= pwdata[autoneg_pkg::ABIL_HI-1:autoneg_pkg::ABIL_LO];
			end
		end
	end

	// override-protected bits: reserved and selector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_rsvd_r <= 1'b0;
			rsvd_r <= autoneg_pkg::RSVD_RST;
		end else if (wr_prot_hi) begin
			ack_rsvd_r <= pwdata[autoneg_pkg::ACK_POS];
			rsvd_r <= pwdata[autoneg_pkg::RSVD_HI:autoneg_pkg::RSVD_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			selector_r <= autoneg_pkg::SEL_RST;
		end else if (wr_prot_lo) begin
			selector_r <= pwdata[autoneg_pkg::SEL_HI:autoneg_pkg::SEL_LO];
		end
	end

	// remote fault tracks the local fault; a software one lasts a cycle unless the fault stays
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_fault_r <= 1'b0;
		end else begin
			remote_fault_r <= local_fault | (wr_adv_hi & pwdata[autoneg_pkg::REMOTE_FAULT_POS]);
		end
	end

	// history resets to the idle level of the fault pin, so reset makes no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_d_r <= 1'b0;
		end else begin
			fault_d_r <= local_fault;
		end
	end

	// events: sticky, write one to clear, a new event wins over its clear
	always_comb begin
		evt_set = '0;
		evt_set[autoneg_pkg::EVT_FAULT_SET] = fault_rise;
		evt_set[autoneg_pkg::EVT_FAULT_CLR] = fault_fall;
		evt_set[autoneg_pkg::EVT_BLOCKED] = blocked & any_lane;
		evt_set[autoneg_pkg::EVT_ADV_CHANGED] = wr_adv & any_lane;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_r <= '0;
		end else if (wr && hit_evt && lo_en) begin
			evt_r <= (evt_r & ~pwdata[autoneg_pkg::EVT_W-1:0]) | evt_set;
		end else begin
			evt_r <= evt_r | evt_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= '0;
		end else if (wr && hit_mask && lo_en) begin
			mask_r <= pwdata[autoneg_pkg::EVT_W-1:0];
		end
	end

	// level output; it drops only when software clears the event or masks it
	assign irq = |(evt_r & mask_r);

	// read mux; reserved positions read zero whatever is stored
	always_comb begin
		prdata_nxt = 32'h0000_0000;
		if (hit_adv) begin
			prdata_nxt[autoneg_pkg::NEXT_PAGE_POS] = next_page_r;
			prdata_nxt[autoneg_pkg::REMOTE_FAULT_POS] = remote_fault_r;
			prdata_nxt[autoneg_pkg::T4_POS] = 1'b0;
			prdata_nxt[autoneg_pkg::ABIL_HI:autoneg_pkg::ABIL_LO] = ability_r;
			prdata_nxt[autoneg_pkg::SEL_HI:autoneg_pkg::SEL_LO] = selector_r;
		end else if (hit_ctrl) begin
			prdata_nxt[autoneg_pkg::CTRL_OVERRIDE_POS] = ctrl_r.override_protected_write;
			prdata_nxt[autoneg_pkg::CTRL_AN_EN_POS] = ctrl_r.an_enable;
			prdata_nxt[autoneg_pkg::CTRL_RATE_POS] = ctrl_r.rate_select;
			prdata_nxt[autoneg_pkg::CTRL_DUPLEX_POS] = ctrl_r.duplex_select;
		end else if (hit_evt) begin
			prdata_nxt[autoneg_pkg::EVT_W-1:0] = evt_r;
		end else if (hit_mask) begin
			prdata_nxt[autoneg_pkg::EVT_W-1:0] = mask_r;
		end else if (hit_info) begin
			prdata_nxt[3:0] = autoneg_pkg::STATUS_ABIL;
			prdata_nxt[4] = hardware_software_select_pin;
			prdata_nxt[5] = local_fault;
		end
	end

	// read data is combinational from registers and the mode and fault pins so the zero-wait answer is correct
	assign prdata = rd ? prdata_nxt : 32'h0000_0000;

	// transmitted code word; the reserved bits carry whatever override let software store
	always_comb begin
		lcw_nxt.next_page = next_page_r;
		lcw_nxt.ack = ack_rsvd_r;
		lcw_nxt.remote_fault = remote_fault_r;
		lcw_nxt.reserved = rsvd_r;
		lcw_nxt.t4 = 1'b0;
		lcw_nxt.technology_ability_field = ability_r;
		lcw_nxt.selector = selector_r;
	end

	// the word goes out a cycle after the register, so the link side sees settled bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_code_word <= '0;
		end else begin
			link_code_word <= lcw_nxt;
		end
	end

	// mode outputs; valid and idle stay low until the defaults are loaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_code_word_valid <= 1'b0;
			forced_idle <= 1'b0;
			forced_rate <= 1'b0;
			forced_duplex <= 1'b0;
		end else begin
			link_code_word_valid <= loaded_r & ctrl_r.an_enable;
			forced_idle <= loaded_r & ~ctrl_r.an_enable;
			forced_rate <= ctrl_r.rate_select;
			forced_duplex <= ctrl_r.duplex_select;
		end
	end

	// status ability never looks at the advertisement bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ability <= autoneg_pkg::STATUS_ABIL;
		end else begin
			status_ability <= autoneg_pkg::STATUS_ABIL;
		end
	end

	assign an_restart = restart_r;
endmodule // autoneg_advertisement_reg

// [pkg/autoneg_pkg.sv]
// package: register map, field layout, reset values and carrier types of the advertisement block
package autoneg_pkg;
	localparam logic [7:0] ADV_OFFSET = 8'h04;
	localparam logic [7:0] CTRL_OFFSET = 8'h40;
	localparam logic [7:0] EVT_OFFSET = 8'h44;
	localparam logic [7:0] MASK_OFFSET = 8'h48;
	localparam logic [7:0] INFO_OFFSET = 8'h4C;

	localparam int NEXT_PAGE_POS = 15;
	localparam int ACK_POS = 14;
	localparam int REMOTE_FAULT_POS = 13;
	localparam int RSVD_HI = 12;
	localparam int RSVD_LO = 10;
	localparam int T4_POS = 9;
	localparam int ABIL_HI = 8;
	localparam int ABIL_LO = 5;
	localparam int SEL_HI = 4;
	localparam int SEL_LO = 0;

	localparam logic NEXT_PAGE_RST = 1'b0;
	localparam logic [2:0] RSVD_RST = 3'h0;
	localparam logic [3:0] ABIL_AN_RST = 4'hF;
	localparam logic [4:0] SEL_RST = 5'h01;
	localparam logic [3:0] STATUS_ABIL = 4'hF;

	// control register fields
	localparam int CTRL_OVERRIDE_POS = 0;
	localparam int CTRL_AN_EN_POS = 1;
	localparam int CTRL_RATE_POS = 2;
	localparam int CTRL_DUPLEX_POS = 3;
	localparam int CTRL_RESTART_POS = 4;

	// event bits, same layout in the mask register
	localparam int EVT_FAULT_SET = 0;
	localparam int EVT_FAULT_CLR = 1;
	localparam int EVT_BLOCKED = 2;
	localparam int EVT_ADV_CHANGED = 3;
	localparam int EVT_W = 4;

	localparam logic [1:0] LOAD_WAIT_RST = 2'h0;

	typedef struct packed {
		logic next_page;
		logic ack;
		logic remote_fault;
		logic [2:0] reserved;
		logic t4;
		logic [3:0] technology_ability_field;
		logic [4:0] selector;
	} link_code_word_t;

	typedef struct packed {
		logic override_protected_write;
		logic an_enable;
		logic rate_select;
		logic duplex_select;
	} adv_ctrl_t;
endpackage

// [tb/adv_props.sv]
// checker: port-level properties of the advertisement block
`timescale 1ns/100ps
module adv_props (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [3:0] pstrb, // strobes
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic local_fault, // fault level
	input wire autoneg_pkg::link_code_word_t link_code_word, // code word
	input wire logic link_code_word_valid, // advertising
	input wire logic an_restart, // restart pulse
	input wire logic forced_idle, // negotiation off
	input wire logic [3:0] status_ability // status bits
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire adv = acc && paddr == autoneg_pkg::ADV_OFFSET;
	wire ctl = acc && paddr == autoneg_pkg::CTRL_OFFSET;
	// the four control-side words sit at 0x40..0x4C
	wire mapped = paddr == 8'h04 || (paddr[7:4] == 4'h4 && paddr[1:0] == 2'h0);
	property p_rsvd; adv && !pwrite |-> prdata[14] == 1'b0 && prdata[12:9] == 4'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
	property p_t4; link_code_word.t4 == 1'b0; endproperty
	a_t4: assert property (p_t4) else $error("t4 bit advertised");
	property p_status; status_ability == 4'hF; endproperty
	a_status: assert property (p_status) else $error("status ability changed");
	property p_err; acc |-> pready && pslverr == !mapped; endproperty
	a_err: assert property (p_err) else $error("bad ready or error");
	property p_fault; $stable(local_fault) [*4] |-> link_code_word.remote_fault == local_fault;
	endproperty
	a_fault: assert property (p_fault) else $error("remote fault not following");
	property p_mode; $past(presetn, 2) |-> link_code_word_valid != forced_idle; endproperty
	a_mode: assert property (p_mode) else $error("valid and idle disagree");
	property p_restart; ctl && pwrite && pstrb[0] && pwdata[4] |=> an_restart ##1 !an_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart pulse wrong");
	property p_adv; adv && pwrite && pstrb == 4'hF |=> ##1
		link_code_word.next_page == $past(pwdata[15], 2) &&
		link_code_word.technology_ability_field == $past(pwdata[8:5], 2); endproperty
	a_adv: assert property (p_adv) else $error("code word not updated");
endmodule // adv_props

// [tb/link_partner.sv]
// partner: link-side model that raises a local fault and hears the code word
`timescale 1ns/100ps
module link_partner (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic fault_req, // bench asks for a fault
	input wire autoneg_pkg::link_code_word_t lcw_in, // word on the pulses
	input wire logic lcw_valid, // word advertised
	output logic local_fault, // fault level
	output logic [15:0] heard_word // last word heard
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_fault <= 1'b0;
			heard_word <= 16'h0000;
		end else begin
			local_fault <= fault_req;
			// a silent link keeps the old word
			if (lcw_valid)
				heard_word <= lcw_in;
		end
	end
endmodule // link_partner

// [tb/tb_top.sv]
// testbench: apb stimulus, read scoreboard, fault and mode scenarios
`timescale 1ns/100ps
module tb_top;
	localparam logic [7:0] ADV = autoneg_pkg::ADV_OFFSET;
	localparam logic [7:0] CTRL = autoneg_pkg::CTRL_OFFSET;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic fault_req = 1'b0;
	logic hw_mode = 1'b0;
	logic strap_an = 1'b1;
	logic strap_rate = 1'b1;
	logic strap_dup = 1'b1;
	logic [31:0] prdata;
	logic pready, pslverr, local_fault, lcw_valid, an_restart;
	logic forced_idle, forced_rate, forced_duplex, irq;
	autoneg_pkg::link_code_word_t lcw;
	logic [3:0] status_ability;
	logic [15:0] heard_word;
	logic [31:0] exp_q[$];
	logic [31:0] d;
	int n_errors = 0;
	int compares = 0;
	int seed = 21;
	autoneg_advertisement_reg autoneg_advertisement_reg_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.hardware_software_select_pin(hw_mode), .strap_an_enable(strap_an), .strap_rate,
		.strap_duplex(strap_dup), .local_fault, .link_code_word(lcw),
		.link_code_word_valid(lcw_valid), .an_restart, .forced_idle, .forced_rate,
		.forced_duplex, .status_ability, .irq);
	link_partner link_partner_i (.pclk, .presetn, .fault_req, .lcw_in(lcw),
		.lcw_valid, .local_fault, .heard_word);
	initial forever #5 pclk = ~pclk;
	task report_and_stop;
		if (n_errors == 0 && compares > 0 && exp_q.size() == 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1) begin
			n_errors++;
			report_and_stop;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h00000000);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		xfer(1'b1, a, v);
	endtask
	always @(posedge pclk)
		if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
			chk("prdata", prdata, exp_q.pop_front());
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		report_and_stop;
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(ADV, 32'h000001E1);
		rd(CTRL, 32'h0000000E);
		rd(8'h4C, 32'h0000000F);
		rd(8'h80, 32'h00000000);
		wr(ADV, 32'h00000000);
		rd(ADV, 32'h00000001);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(8'h48, 32'h00000004);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(8'h44, 32'h00000004);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(CTRL, 32'h0000000F);
		wr(ADV, 32'h00008002);
		rd(ADV, 32'h00008002);
		wr(ADV, 32'h000001E1);
		wr(CTRL, 32'h0000000E);
		for (int i = 0; i < 8; i++) begin
			// reserved and read-only places always written as zero
			d = {16'h0000, 1'($random(seed)), 6'h00, 4'($random(seed)), 5'h01};
			wr(ADV, d);
			rd(ADV, d);
			@(posedge pclk);
			chk("heard", {16'h0000, heard_word}, d);
		end
		fault_req <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(ADV, d | 32'h00002000);
		rd(8'h4C, 32'h0000002F);
		fault_req <= 1'b0;
		repeat (4) @(posedge pclk);
		rd(ADV, d);
		wr(CTRL, 32'h0000001E);
		wr(CTRL, 32'h0000000C);
		@(posedge pclk);
		chk("idle", {31'h0, forced_idle}, 32'h1);
		chk("rate", {31'h0, forced_rate}, 32'h1);
		chk("duplex", {31'h0, forced_duplex}, 32'h1);
		wr(CTRL, 32'h0000000E);
		// hardware mode, negotiation strapped off at 100M half: only that mode is offered
		hw_mode <= 1'b1;
		strap_an <= 1'b0;
		strap_dup <= 1'b0;
		presetn <= 1'b0;
		// four cycles, so the two-cycle history of the mode check lies inside reset
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(ADV, 32'h00000081);
		rd(CTRL, 32'h00000004);
		rd(8'h4C, 32'h0000001F);
		chk("idle", {31'h0, forced_idle}, 32'h1);
		chk("valid", {31'h0, lcw_valid}, 32'h0);
		report_and_stop;
	end
endmodule // tb_top
bind autoneg_advertisement_reg adv_props adv_props_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .local_fault,
	.link_code_word, .link_code_word_valid, .an_restart, .forced_idle, .status_ability);
